// *** logic/clock_frequency_control_regs.svh ***
`ifndef CLOCK_FREQUENCY_CONTROL_REGS_SVH
`define CLOCK_FREQUENCY_CONTROL_REGS_SVH

// Register byte offset on the bus
`define FCR_OFFSET 4'h0

// Field positions of the frequency control register
`define FCR_RSVD_HI 15
`define FCR_RSVD_LO 12
`define FCR_CLK_OUT_EN_BIT 11
`define FCR_PLLA_BIT 10
`define FCR_PLLB_BIT 9
`define FCR_CPU_HI 8
`define FCR_CPU_LO 6
`define FCR_BUS_HI 5
`define FCR_BUS_LO 3
`define FCR_PER_HI 2
`define FCR_PER_LO 0

// Power-on values per clock operating mode
`define FCR_INIT_M0 16'h0E1A
`define FCR_INIT_M1 16'h0E23
`define FCR_INIT_M1_ALT 16'h0E2C
`define FCR_INIT_M2 16'h0E13
`define FCR_INIT_M3 16'h0E13
`define FCR_INIT_M4 16'h0E0A
`define FCR_INIT_M5 16'h0E0A
`define FCR_INIT_M6 16'h0808
`define FCR_INIT_M7 16'h0808

// Clock operating mode codes
`define MODE_0 3'h0
`define MODE_1 3'h1
`define MODE_2 3'h2
`define MODE_3 3'h3
`define MODE_4 3'h4
`define MODE_5 3'h5
`define MODE_6 3'h6

// Fixed multiplication factors of the first PLL
`define PLLA_MULT_HI 5'h0C
`define PLLA_MULT_LO 5'h06

// Divider codes and their divisors
`define DIV_CODE_0 3'h0
`define DIV_CODE_1 3'h1
`define DIV_CODE_2 3'h2
`define DIV_CODE_3 3'h3
`define DIV_CODE_4 3'h4
`define DIV_CODE_5 3'h5
`define DIVISOR_1 4'h1
`define DIVISOR_2 4'h2
`define DIVISOR_3 4'h3
`define DIVISOR_4 4'h4
`define DIVISOR_6 4'h6
`define DIVISOR_8 4'h8
`define DIVISOR_BAD 4'h0

// Wishbone lane enables for a full low half-word
`define SEL_LOW_HALF 2'h3

// Cycles after reset release before the mode pins are trusted
`define SYNC_WAIT 2'h3

`endif

// *** logic/clock_frequency_control_pkg.sv ***
package clock_frequency_control_pkg;

  // Settings that steer the clock generator
  typedef struct packed {
    logic clk_out_en;
    logic pll_a_en;
    logic pll_b_en;
    logic [2:0] cpu_div_sel;
    logic [2:0] bus_div_sel;
    logic [2:0] periph_div_sel;
  } freq_settings_t;

  // Divisors presently applied to the three clocks
  typedef struct packed {
    logic [3:0] cpu;
    logic [3:0] bus;
    logic [3:0] periph;
  } div_ratio_t;

  // Oscillation stabilization sequence
  typedef enum logic [1:0] {
    STAB_IDLE,
    STAB_WAIT_A,
    STAB_WAIT_B
  } stab_state_t;

endpackage

// *** logic/clock_frequency_control.sv ***
// Behaviour
// RULE1: 16-bit read/write control register, reachable only by whole-word access; reads here ignore wb_sel_i.
// RULE2: Only power-on reset loads it, from mode table; other resets keep it.
// RULE3: Bits 15 to 12 read zero; software writes only zero there.
// RULE4: Bit 11 high drives clock pin; low floats it with pull-up.
// RULE5: Floating the clock pin leaves internal clock frequencies unchanged.
// RULE6: No pull-up on the clock pin during hardware standby.
// RULE7: Bit 10 uses first PLL when high, bypasses it when low.
// RULE8: Bit 9 uses second PLL when high, bypasses it when low.
// RULE9: CPU divider codes 0..5 give divide by 1,2,3,4,6,8.
// RULE10: Bus divider uses the CPU mapping; codes above five prohibited.
// RULE11: Peripheral divider codes 0..4 give divide by 2,3,4,6,8.
// RULE12: Software writes only listed divider combinations into lower nine bits.
// RULE13: First PLL multiplication factor comes from operating mode only.
// RULE14: Three mode pins select operating mode and initial configuration.
// RULE15: Starting first PLL halts internal clock until watchdog overflow.
// RULE16: Bus divider change applies at once unless second PLL runs.
// RULE17: CPU and peripheral divider changes apply at once.
// RULE18: Reads return applied settings, reserved bits zero; the bus field reads the last written code.
// RULE19: New settings take effect only when the word write completes.
`timescale 1ns/100ps
`default_nettype none

`include "clock_frequency_control_regs.svh"

module clock_frequency_control
  import clock_frequency_control_pkg::*;
#(
  parameter int ADDR_W = 4,
  parameter bit ALT_TABLE = 1'b0
) (
  // Clock and resets
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sys_rst_i,
  // Wishbone classic slave
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Mode and standby pins
  input wire logic [2:0] clock_mode_pins_i,
  input wire logic hw_standby_i,
  // Watchdog stabilization count
  input wire logic wdt_ovf_i,
  output logic wdt_start_o,
  // Clock generator control
  output logic pll_a_en_o,
  output logic pll_b_en_o,
  output logic [4:0] pll_a_mult_o,
  output logic half_div_en_o,
  output logic [3:0] cpu_div_o,
  output logic [3:0] bus_div_o,
  output logic [3:0] periph_div_o,
  output logic clk_halt_o,
  // External clock pin
  input wire logic clk_out_src_i,
  output logic clk_out_pin_o,
  output logic clk_out_pin_oe_o,
  output logic clk_out_pullup_o,
  output logic clk_out_unstable_o
);

  // Elaboration check: the decode needs at least a two-bit address
  if (ADDR_W < 2) begin : g_bad_addr_w
    $error("ADDR_W must be at least 2");
  end

  // CPU and bus divider decode
  function automatic logic [3:0] main_divisor(input logic [2:0] code);
    logic [3:0] d;
    d = `DIVISOR_BAD;
    unique case (code)
      `DIV_CODE_0: d = `DIVISOR_1;
      `DIV_CODE_1: d = `DIVISOR_2;
      `DIV_CODE_2: d = `DIVISOR_3;
      `DIV_CODE_3: d = `DIVISOR_4;
      `DIV_CODE_4: d = `DIVISOR_6;
      `DIV_CODE_5: d = `DIVISOR_8;
      default: d = `DIVISOR_BAD;
    endcase
    return d;
  endfunction

  // Peripheral divider decode
  function automatic logic [3:0] periph_divisor(input logic [2:0] code);
    logic [3:0] d;
    d = `DIVISOR_BAD;
    unique case (code)
      `DIV_CODE_0: d = `DIVISOR_2;
      `DIV_CODE_1: d = `DIVISOR_3;
      `DIV_CODE_2: d = `DIVISOR_4;
      `DIV_CODE_3: d = `DIVISOR_6;
      `DIV_CODE_4: d = `DIVISOR_8;
      default: d = `DIVISOR_BAD;
    endcase
    return d;
  endfunction

  // Power-on value for a mode
  function automatic logic [15:0] mode_init(input logic [2:0] mode);
    logic [15:0] v;
    v = `FCR_INIT_M7;
    unique case (mode)
      `MODE_0: v = `FCR_INIT_M0;
      `MODE_1: v = ALT_TABLE ? `FCR_INIT_M1_ALT : `FCR_INIT_M1;
      `MODE_2: v = `FCR_INIT_M2;
      `MODE_3: v = `FCR_INIT_M3;
      `MODE_4: v = `FCR_INIT_M4;
      `MODE_5: v = `FCR_INIT_M5;
      `MODE_6: v = `FCR_INIT_M6;
      default: v = `FCR_INIT_M7;
    endcase
    return v;
  endfunction

  // Word to settings
  function automatic freq_settings_t unpack_word(input logic [15:0] w);
    freq_settings_t s;
    s.clk_out_en = w[`FCR_CLK_OUT_EN_BIT];
    s.pll_a_en = w[`FCR_PLLA_BIT];
    s.pll_b_en = w[`FCR_PLLB_BIT];
    s.cpu_div_sel = w[`FCR_CPU_HI:`FCR_CPU_LO];
    s.bus_div_sel = w[`FCR_BUS_HI:`FCR_BUS_LO];
    s.periph_div_sel = w[`FCR_PER_HI:`FCR_PER_LO];
    return s;
  endfunction

  logic [2:0] mode_s1_r, mode_s2_r, mode_s3_r;
  logic stby_s1_r, stby_s2_r, stby_s3_r;
  logic [2:0] mode_r;
  logic stby_r;
  logic init_pend_r;
  logic [1:0] init_cnt_r;
  freq_settings_t set_r;
  freq_settings_t wr_set;
  freq_settings_t init_set;
  logic [2:0] bus_applied_r;
  logic [2:0] bus_pend_r;
  stab_state_t state_r, state_nxt;
  logic ack_r;
  logic [31:0] rdat_r;
  logic wdt_start_r;
  logic req;
  logic hit;
  logic wr_take;
  logic pll_a_start;
  logic bus_restab;

  // Mode and standby pin synchronisers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_s1_r <= 3'h0;
      mode_s2_r <= 3'h0;
      mode_s3_r <= 3'h0;
      stby_s1_r <= 1'b0;
      stby_s2_r <= 1'b0;
      stby_s3_r <= 1'b0;
    end else begin
      mode_s1_r <= clock_mode_pins_i;
      mode_s2_r <= mode_s1_r;
      mode_s3_r <= mode_s2_r;
      stby_s1_r <= hw_standby_i;
      stby_s2_r <= stby_s1_r;
      stby_s3_r <= stby_s2_r;
    end
  end

  // Filtered levels, taken when the last two stages agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= 3'h0;
      stby_r <= 1'b0;
    end else begin
      if (mode_s2_r == mode_s3_r) begin
        mode_r <= mode_s3_r; // [RULE14]
      end
      if (stby_s2_r == stby_s3_r) begin
        stby_r <= stby_s3_r;
      end
    end
  end

  // Wait for the mode pins to pass the synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      init_pend_r <= 1'b1;
      init_cnt_r <= 2'h0;
    end else if (init_pend_r) begin
      if (init_cnt_r == `SYNC_WAIT && mode_s2_r == mode_s3_r) begin
        init_pend_r <= 1'b0;
      end else if (init_cnt_r != `SYNC_WAIT) begin
        init_cnt_r <= init_cnt_r + 2'h1;
      end
    end
  end

  // Bus decode
  assign req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign hit = (wb_adr_i == ADDR_W'(`FCR_OFFSET));
  assign wr_take = req & wb_we_i & hit & ~init_pend_r &
                   (wb_sel_i[1:0] == `SEL_LOW_HALF) & // [RULE1]
                   (state_r == STAB_IDLE);
  assign wr_set = unpack_word(wb_dat_i[15:0]); // [RULE3]
  // Power-on settings for the mode now seen on the pins
  assign init_set = unpack_word(mode_init(mode_s3_r)); // [RULE14]
  assign pll_a_start = wr_take & ~set_r.pll_a_en & wr_set.pll_a_en;
  assign bus_restab = wr_take & set_r.pll_b_en &
                      (wr_set.bus_div_sel != set_r.bus_div_sel);

  // Control register, initialised only by power-on reset, then loaded by accepted writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      set_r <= '0;
    end else if (init_pend_r) begin
      if (init_cnt_r == `SYNC_WAIT && mode_s2_r == mode_s3_r) begin
        set_r <= init_set; // [RULE2]
      end
    end else if (wr_take) begin
      set_r <= wr_set; // [RULE19]
    end
  end

  // Bus divider applied to the clock tree
  // The pending copy follows every accepted write, so a second-PLL
  // count entered after a first-PLL start never applies a stale code
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_applied_r <= 3'h0;
      bus_pend_r <= 3'h0;
    end else if (init_pend_r) begin
      bus_applied_r <= init_set.bus_div_sel;
      bus_pend_r <= init_set.bus_div_sel;
    end else if (wr_take) begin
      bus_pend_r <= wr_set.bus_div_sel;
      if (!bus_restab) begin
        bus_applied_r <= wr_set.bus_div_sel; // [RULE16]
      end
    end else if (state_r == STAB_WAIT_B && wdt_ovf_i) begin
      bus_applied_r <= bus_pend_r; // [RULE16]
    end
  end

  // Stabilization state
  always_ff @(posedge clk_i) begin
    if (rst_i || sys_rst_i) begin
      state_r <= STAB_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Stabilization sequencing
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      STAB_IDLE: begin
        if (pll_a_start) begin
          state_nxt = STAB_WAIT_A; // [RULE15]
        end else if (bus_restab) begin
          state_nxt = STAB_WAIT_B; // [RULE16]
        end
      end
      STAB_WAIT_A: begin
        if (wdt_ovf_i) begin
          state_nxt = set_r.pll_b_en ? STAB_WAIT_B : STAB_IDLE; // [RULE15]
        end
      end
      STAB_WAIT_B: begin
        if (wdt_ovf_i) begin
          state_nxt = STAB_IDLE;
        end
      end
    endcase
  end

  // Watchdog start pulse at the start of each count
  always_ff @(posedge clk_i) begin
    if (rst_i || sys_rst_i) begin
      wdt_start_r <= 1'b0;
    end else begin
      wdt_start_r <= (state_r == STAB_IDLE && state_nxt != STAB_IDLE) ||
                     (state_r == STAB_WAIT_A && state_nxt == STAB_WAIT_B);
    end
  end

  // Acknowledge every request one cycle later
  always_ff @(posedge clk_i) begin
    if (rst_i || sys_rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  // Read data, reserved and unmapped bits zero
  always_ff @(posedge clk_i) begin
    if (rst_i || sys_rst_i) begin
      rdat_r <= 32'h0;
    end else if (req && !wb_we_i && hit) begin
      rdat_r <= {20'h0, set_r}; // [RULE18] [RULE3]
    end else begin
      rdat_r <= 32'h0;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign wdt_start_o = wdt_start_r;

  // Generator controls
  assign pll_a_en_o = set_r.pll_a_en; // [RULE7]
  assign pll_b_en_o = set_r.pll_b_en; // [RULE8]
  assign cpu_div_o = main_divisor(set_r.cpu_div_sel); // [RULE9] [RULE17]
  assign bus_div_o = main_divisor(bus_applied_r); // [RULE10]
  assign periph_div_o = periph_divisor(set_r.periph_div_sel); // [RULE11]
  assign clk_halt_o = (state_r != STAB_IDLE) | init_pend_r; // [RULE15]

  // Mode-fixed PLL factor and half divider
  assign pll_a_mult_o = (mode_r == `MODE_2 || mode_r == `MODE_4 ||
                         mode_r == `MODE_6) ?
                        `PLLA_MULT_LO : `PLLA_MULT_HI; // [RULE13]
  assign half_div_en_o = ~ALT_TABLE &
                         (mode_r == `MODE_2 || mode_r == `MODE_4);

  // Clock pin drive; dividers untouched by the enable
  assign clk_out_pin_o = clk_out_src_i & set_r.clk_out_en; // [RULE5]
  assign clk_out_pin_oe_o = set_r.clk_out_en; // [RULE4]
  assign clk_out_pullup_o = ~set_r.clk_out_en & ~stby_r; // [RULE4] [RULE6]
  assign clk_out_unstable_o = (state_r != STAB_IDLE); // [RULE15]

endmodule // clock_frequency_control

`default_nettype wire

// *** verification/clock_frequency_control_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module clock_frequency_control_props (
  // Clock and resets
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sys_rst_i,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // Pins and clock control
  input wire logic hw_standby_i,
  input wire logic clk_out_src_i,
  input wire logic clk_out_pin_o,
  input wire logic clk_out_pin_oe_o,
  input wire logic clk_out_pullup_o,
  input wire logic pll_a_en_o,
  input wire logic [4:0] pll_a_mult_o,
  input wire logic wdt_start_o,
  input wire logic clk_halt_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i || sys_rst_i);
  // Bus answer timing and read data
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_rsvd_zero: assert property (wb_dat_o[31:12] == 20'h0)
    else $error("reserved bits set");
  a_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("data outside ack");
  // Clock pin control
  a_pin_gated: assert property (clk_out_pin_o == (clk_out_src_i && clk_out_pin_oe_o))
    else $error("pin level wrong");
  a_oe_no_pull: assert property (clk_out_pin_oe_o |-> !clk_out_pullup_o)
    else $error("pullup while driven");
  a_standby_no_pull: assert property (hw_standby_i [*5] |-> !clk_out_pullup_o)
    else $error("pullup in standby");
  // PLL factor, start sequence and write timing
  a_mult_fixed: assert property (pll_a_mult_o == 5'h0C || pll_a_mult_o == 5'h06)
    else $error("bad factor");
  a_start_halts: assert property ($rose(pll_a_en_o) && !$past(clk_halt_o) |-> clk_halt_o && wdt_start_o)
    else $error("no halt on start");
  a_change_on_write: assert property ($changed(pll_a_en_o) && !$past(clk_halt_o) |-> wb_ack_o && $past(wb_we_i))
    else $error("change without write");
  // Main scenarios
  c_start: cover property (wdt_start_o);
  c_read: cover property (wb_ack_o && !wb_we_i);
  c_float: cover property ($fell(clk_out_pin_oe_o));
endmodule // clock_frequency_control_props
bind clock_frequency_control clock_frequency_control_props u_props (.*);
`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
  // Stimulus and observed signals
  logic clk_i = 0, rst_i = 1, sys_rst_i = 0, we = 0, cyc = 0, stb = 0;
  logic stby = 0, ovf = 0, src = 0, ack, wst, pa, pb, halt, pin, oe, pu;
  logic [3:0] adr = 4'h0, sel = 4'h0, cd, bd, pd;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic uns, hd;
  logic [2:0] mode = 3'h0;
  logic [4:0] mult;
  logic [15:0] iv [8] = '{16'h0E1A, 16'h0E23, 16'h0E13, 16'h0E13,
    16'h0E0A, 16'h0E0A, 16'h0808, 16'h0808};
  logic [8:0] lv [6] = '{9'h000, 9'h04A, 9'h091, 9'h0DC, 9'h123, 9'h16C};
  logic [11:0] ev [6] = '{12'h112, 12'h224, 12'h333, 12'h448, 12'h666,
    12'h888};
  int n_fail = 0, n_compared = 0, cyc_n = 0;
  clock_frequency_control dut (.clk_i(clk_i), .rst_i(rst_i),
    .sys_rst_i(sys_rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_dat_o(rdat), .wb_ack_o(ack), .clock_mode_pins_i(mode),
    .hw_standby_i(stby), .wdt_ovf_i(ovf), .wdt_start_o(wst),
    .pll_a_en_o(pa), .pll_b_en_o(pb), .pll_a_mult_o(mult),
    .half_div_en_o(hd), .cpu_div_o(cd), .bus_div_o(bd),
    .periph_div_o(pd), .clk_halt_o(halt), .clk_out_src_i(src),
    .clk_out_pin_o(pin), .clk_out_pin_oe_o(oe),
    .clk_out_pullup_o(pu), .clk_out_unstable_o(uns));
  // Clock
  initial forever #12.5 clk_i = ~clk_i;
  // Toggling pin source and hang guard
  always @(posedge clk_i) begin
    src <= ~src;
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      n_fail++;
      test_done;
    end
  end
  task test_done;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      $display("Error at %0t: got %h expected %h", $time, g, e);
      n_fail++;
    end
  endtask
  // Classic single bus cycle
  task wb(input logic [3:0] a, input logic w, input logic [15:0] d,
    input logic [3:0] s);
    int i;
    @(posedge clk_i);
    adr <= a; we <= w; wdat <= {16'h0, d}; sel <= s; cyc <= 1; stb <= 1;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack !== 1'b1 && i < 20);
    q = rdat;
    cyc <= 0; stb <= 0; we <= 0;
  endtask
  task rd_chk(input logic [15:0] e);
    wb(4'h0, 1'b0, 16'h0, 4'hF);
    chk(q, {16'h0, e});
  endtask
  task settle;
    int i;
    for (i = 0; i < 40 && halt !== 1'b0; i++) @(posedge clk_i);
    chk(halt, 0);
  endtask
  // Answer each watchdog start with an overflow
  task stab(input int n);
    int i;
    repeat (n) begin
      for (i = 0; i < 40 && wst !== 1'b1; i++) @(posedge clk_i);
      chk(wst, 1);
      ovf <= 1;
      @(posedge clk_i);
      ovf <= 0;
    end
    settle;
  endtask
  task por(input logic [2:0] m);
    @(posedge clk_i);
    rst_i <= 1; mode <= m;
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    settle;
  endtask
  task t_modes;
    for (int m = 0; m < 8; m++) begin
      por(3'(m));
      rd_chk(iv[m]);
      chk(mult, (m == 2 || m == 4 || m == 6) ? 5'h06 : 5'h0C);
      chk(hd, (m == 2 || m == 4) ? 1 : 0);
    end
    por(3'h0);
    chk({oe, pa, pb, cd, bd, pd}, 15'h7144);
  endtask
  task t_div;
    wb(4'h0, 1'b1, 16'h081A, 4'hF);
    chk({pa, pb, halt}, 3'h0);
    for (int k = 0; k < 6; k++) begin
      wb(4'h0, 1'b1, 16'h0800 | 16'(lv[k]), 4'hF);
      chk({cd, bd, pd}, ev[k]);
      rd_chk(16'h0800 | 16'(lv[k]));
    end
  endtask
  task t_pin;
    wb(4'h0, 1'b1, 16'h016C, 4'hF);
    chk({oe, pu, pin, cd, bd, pd}, 15'h2888);
    stby <= 1;
    repeat (6) @(posedge clk_i);
    chk(pu, 0);
    stby <= 0;
    repeat (6) @(posedge clk_i);
    chk(pu, 1);
    wb(4'h0, 1'b1, 16'h096C, 4'hF);
    chk({oe, pu}, 2'h2);
  endtask
  task t_refuse;
    wb(4'h0, 1'b1, 16'h0800, 4'h1);
    wb(4'h4, 1'b1, 16'h0800, 4'hF);
    rd_chk(16'h096C);
    wb(4'h4, 1'b0, 16'h0, 4'hF);
    chk(q, 0);
    @(posedge clk_i);
    sys_rst_i <= 1;
    @(posedge clk_i);
    sys_rst_i <= 0;
    rd_chk(16'h096C);
  endtask
  task t_pll;
    wb(4'h0, 1'b1, 16'h0F6C, 4'hF);
    chk({halt, uns}, 2'h3);
    stab(2);
    rd_chk(16'h0F6C);
    wb(4'h0, 1'b1, 16'h0F23, 4'hF);
    chk({cd, bd}, 8'h68);
    stab(1);
    chk({cd, bd, pd}, 12'h666);
  endtask
  // Main sequence
  initial begin
    t_modes;
    t_div;
    t_pin;
    t_refuse;
    t_pll;
    test_done;
  end
endmodule // tb
`default_nettype wire
